// ### rtl/svi_defs.svh
// Register offsets, field positions, reset values, the call vector and status bit positions
`ifndef SVI_DEFS_SVH
`define SVI_DEFS_SVH
`define SVI_OFF_ENABLE 12'hf08
`define SVI_OFF_PENDING 12'hf09
`define SVI_OFF_CTRL 12'hf0c
`define SVI_OFF_STATUS 12'hf10
`define SVI_OFF_HMASK 12'hf14
`define SVI_OFF_HSTAT 12'hf18
`define SVI_BIT_PWM_A 3
`define SVI_BIT_PWM_B 2
`define SVI_BIT_TMR_B 1
`define SVI_BIT_TMR_A 0
`define SVI_BIT_WAKEUP 3
`define SVI_BIT_EXT_C 2
`define SVI_BIT_EXT_B 1
`define SVI_BIT_EXT_A 0
`define SVI_POS_PWM_A 7
`define SVI_POS_PWM_B 6
`define SVI_POS_TMR_B 5
`define SVI_POS_TMR_A 4
`define SVI_POS_WAKEUP 3
`define SVI_POS_EXT_C 2
`define SVI_POS_EXT_B 1
`define SVI_POS_EXT_A 0
`define SVI_POS_EDGE_SEL 7
`define SVI_RST_HMASK 2'h0
`define SVI_RST_HSTAT 2'h0
`define SVI_RST_ENABLE 8'h00
`define SVI_RST_PENDING 8'h00
`define SVI_RST_CTRL 8'h00
`define SVI_VECTOR 12'h001
`define SVI_HEV_TAKEN 0
`define SVI_HEV_SERVICE_END 1
`endif

// ### rtl/svi_pkg.sv
// Types shared by the interrupt unit
package svi_pkg;
  typedef enum logic [2:0] {
    SVI_IDLE = 3'b001,
    SVI_BUSY = 3'b010,
    SVI_HOLD = 3'b100
  } svi_state_t;
  typedef logic [7:0] svi_byte_t;
endpackage : svi_pkg

// ### rtl/svi_irq_unit.sv
// Single-level single-vector interrupt unit with AHB-Lite registers
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "svi_defs.svh"
module svi_irq_unit #(
  parameter int N_SRC = 8,
  parameter int N_PIN = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] periph_event,
  input wire logic wakeup_timer_event,
  input wire logic port_a_line6,
  input wire logic port_a_line1,
  input wire logic port_a_line7,
  input wire logic instr_end,
  input wire logic return_from_irq,
  output logic cpu_irq_req,
  output logic inject_call,
  output logic [11:0] inject_addr,
  output logic in_service,
  output logic irq
);
  import svi_pkg::*;

  // The register layout fixes the source count and the pin count
  if (N_SRC != 8) begin : g_bad_src
    $error("svi_irq_unit serves exactly eight sources");
  end
  if (N_PIN != 3) begin : g_bad_pin
    $error("svi_irq_unit serves exactly three pins");
  end

  // Pending flags and enables
  svi_byte_t irq_enable_bits_q;
  svi_byte_t irq_pending_bits_q, irq_pending_bits_d;
  svi_byte_t ctrl_q;
  logic [1:0] hstat_q, hmask_q;
  svi_state_t state_q, state_d;

  // Pin synchronisers: three stages, a change counts once stages two and
  // three agree, so a single sampled glitch cannot fake an edge
  wire [N_PIN-1:0] pin_raw = {port_a_line7, port_a_line1,
    port_a_line6};
  wire [N_PIN-1:0] pin_fall;
  wire [N_PIN-1:0] pin_rise;
  for (genvar p = 0; p < N_PIN; p++) begin : g_pin
    logic [2:0] sync_q;
    logic lvl_q;
    wire lvl_new = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
    // Pins idle high; resetting high avoids a false edge after reset
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sync_q <= 3'h7;
        lvl_q <= 1'b1;
      end else begin
        sync_q <= {sync_q[1:0], pin_raw[p]};
        lvl_q <= lvl_new;
      end
    end
    assign pin_fall[p] = lvl_q & ~lvl_new;
    assign pin_rise[p] = ~lvl_q & lvl_new;
  end

  wire edge_sel = ctrl_q[`SVI_POS_EDGE_SEL];
  wire ext_a_fall = pin_fall[0];
  wire ext_c_fall = pin_fall[2];
  wire ext_b_hit = edge_sel ? pin_rise[1] : pin_fall[1];

  // Event vector in the pending-register layout
  wire [7:0] ev = {periph_event[`SVI_BIT_PWM_A],
    periph_event[`SVI_BIT_PWM_B], periph_event[`SVI_BIT_TMR_B],
    periph_event[`SVI_BIT_TMR_A], wakeup_timer_event,
    ext_c_fall, ext_b_hit, ext_a_fall};

  // AHB-Lite address phase capture; one register per word, so the
  // word index haddr[13:2] is what the offsets are compared with
  logic wr_q, rd_q;
  logic [11:0] addr_q;
  wire take = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_q <= take & hwrite;
      rd_q <= take & ~hwrite;
      addr_q <= haddr[13:2];
    end
  end

  wire sel_enable = (addr_q == `SVI_OFF_ENABLE);
  wire sel_pending = (addr_q == `SVI_OFF_PENDING);
  wire sel_ctrl = (addr_q == `SVI_OFF_CTRL);
  wire sel_status = (addr_q == `SVI_OFF_STATUS);
  wire sel_hmask = (addr_q == `SVI_OFF_HMASK);
  wire sel_hstat = (addr_q == `SVI_OFF_HSTAT);

  wire wr_en = wr_q & sel_enable;
  wire wr_pd = wr_q & sel_pending;
  wire wr_ct = wr_q & sel_ctrl;
  wire wr_hs = wr_q & sel_hstat;
  wire wr_hm = wr_q & sel_hmask;

  // Software writes 0 to clear; a same-cycle event still wins
  always_comb begin
    irq_pending_bits_d = irq_pending_bits_q;
    if (wr_pd) irq_pending_bits_d = irq_pending_bits_q & hwdata[7:0];
    irq_pending_bits_d = irq_pending_bits_d | ev;
  end

  // Request per enabled pending source; no priority among them
  wire pwm_a_period_enable = irq_enable_bits_q[`SVI_POS_PWM_A];
  wire pwm_b_period_enable = irq_enable_bits_q[`SVI_POS_PWM_B];
  wire timer_b_overflow_enable = irq_enable_bits_q[`SVI_POS_TMR_B];
  wire timer_a_overflow_enable = irq_enable_bits_q[`SVI_POS_TMR_A];
  wire wakeup_timer_enable = irq_enable_bits_q[`SVI_POS_WAKEUP];
  wire ext_pin_c_enable = irq_enable_bits_q[`SVI_POS_EXT_C];
  wire ext_pin_b_enable = irq_enable_bits_q[`SVI_POS_EXT_B];
  wire ext_pin_a_enable = irq_enable_bits_q[`SVI_POS_EXT_A];
  wire [7:0] en_view = {pwm_a_period_enable, pwm_b_period_enable,
    timer_b_overflow_enable, timer_a_overflow_enable, wakeup_timer_enable,
    ext_pin_c_enable, ext_pin_b_enable, ext_pin_a_enable};

  wire [N_SRC-1:0] src_req;
  for (genvar i = 0; i < N_SRC; i++) begin : g_src
    assign src_req[i] = irq_pending_bits_q[i] & en_view[i];
  end
  wire [7:0] active = src_req;
  wire req_any = |active;

  // In-service sequence: BUSY until return, HOLD for the next
  // instruction, which clears the flag at its end
  wire accept = (state_q == SVI_IDLE) & req_any & instr_end;
  always_comb begin
    state_d = state_q;
    case (state_q)
      SVI_IDLE: if (accept) state_d = SVI_BUSY;
      SVI_BUSY: if (instr_end & return_from_irq) state_d = SVI_HOLD;
      SVI_HOLD: if (instr_end) state_d = SVI_IDLE;
      default: state_d = SVI_IDLE;
    endcase
  end

  wire service_end = (state_q == SVI_HOLD) & instr_end;
  wire [1:0] hev = {service_end, accept};
  // Write one to clear; an event in the same cycle still sets the bit
  wire [1:0] hstat_d = (wr_hs ? (hstat_q & ~hwdata[1:0]) : hstat_q) | hev;

  // HOLD's instruction is the main-program one; acceptance only from IDLE
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= SVI_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Pending flags take events every cycle, enabled or not
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pending_bits_q <= `SVI_RST_PENDING;
    end else begin
      irq_pending_bits_q <= irq_pending_bits_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable_bits_q <= `SVI_RST_ENABLE;
    end else if (wr_en) begin
      irq_enable_bits_q <= hwdata[7:0];
    end
  end

  // Only the edge-select bit is kept; the other bits read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `SVI_RST_CTRL;
    end else if (wr_ct) begin
      ctrl_q <= hwdata[7:0] & 8'h80;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hmask_q <= `SVI_RST_HMASK;
    end else if (wr_hm) begin
      hmask_q <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hstat_q <= `SVI_RST_HSTAT;
    end else begin
      hstat_q <= hstat_d;
    end
  end

  // Read mux; unmapped addresses read zero
  wire [7:0] status_word = {5'h00, state_q != SVI_IDLE, req_any, 1'b0};
  wire [7:0] rsel =
    sel_enable ? irq_enable_bits_q :
    sel_pending ? irq_pending_bits_q :
    sel_ctrl ? ctrl_q :
    sel_status ? status_word :
    sel_hmask ? {6'h00, hmask_q} :
    sel_hstat ? {6'h00, hstat_q} : 8'h00;

  // Outputs straight from flip-flops; read data in the data phase
  // needs the address, so the slave inserts one wait state on reads
  logic rd_wait_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      rd_wait_q <= 1'b0;
      hresp <= 1'b0;
    end else begin
      rd_wait_q <= take & ~hwrite;
      hreadyout <= ~(take & ~hwrite);
      if (rd_q) hrdata <= {24'h00_0000, rsel};
    end
  end

  // Request from the next pending value, so a fresh event shows at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_irq_req <= 1'b0;
    end else begin
      cpu_irq_req <= |(irq_pending_bits_d & irq_enable_bits_q);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inject_call <= 1'b0;
      inject_addr <= 12'h000;
    end else begin
      inject_call <= accept;
      inject_addr <= `SVI_VECTOR;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_service <= 1'b0;
    end else begin
      in_service <= (state_d != SVI_IDLE);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(hstat_d & hmask_q);
    end
  end
endmodule : svi_irq_unit

// ### tb/svi_irq_unit_assertions.sv
// Port-level checks of the interrupt unit
`timescale 1ns/1ps
module svi_irq_unit_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic instr_end,
  input wire logic return_from_irq,
  input wire logic cpu_irq_req,
  input wire logic inject_call,
  input wire logic [11:0] inject_addr,
  input wire logic in_service
);
  logic wr_q;
  // A request may only drop in the data phase of a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_q <= 1'b0;
    else wr_q <= hsel && hready && htrans[1] && hwrite;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  call_vector_a: assert property (
    inject_call |-> inject_addr == 12'h001) else $error("vector");
  call_at_end_a: assert property (
    inject_call |-> $past(instr_end)) else $error("mid call");
  no_nesting_a: assert property (
    inject_call |-> !$past(in_service)) else $error("nested");
  accept_req_a: assert property (
    instr_end && cpu_irq_req && !in_service |=> inject_call)
    else $error("no accept");
  ret_hold_a: assert property (
    instr_end && return_from_irq |=> in_service [*2]) else $error("early");
  rise_call_a: assert property (
    $rose(in_service) |-> inject_call) else $error("flag");
  level_req_a: assert property (
    $fell(cpu_irq_req) |-> $past(wr_q)) else $error("req drop");
  held_req_a: assert property (
    $fell(in_service) && cpu_irq_req |-> ##[1:4] inject_call)
    else $error("lost");
endmodule : svi_irq_unit_assertions

// ### tb/svi_cpu_model.sv
// Instruction sequencer stand-in: ends an instruction every P cycles
`timescale 1ns/1ps
module svi_cpu_model #(parameter int P = 3) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ret_req,
  output logic instr_end,
  output logic return_from_irq
);
  int c;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c <= 0;
      instr_end <= 1'b0;
      return_from_irq <= 1'b0;
    end else begin
      c <= (c == P - 1) ? 0 : c + 1;
      instr_end <= (c == P - 1);
      return_from_irq <= ret_req && (c == P - 1);
    end
  end
endmodule : svi_cpu_model

// ### tb/svi_irq_unit_tb.sv
// Register, service and pin walk for the interrupt unit
`timescale 1ns/1ps
module svi_irq_unit_tb;
  logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, ret_req = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] periph_event = 4'h0;
  logic wakeup_timer_event = 0, port_a_line6 = 1;
  logic port_a_line1 = 1, port_a_line7 = 1;
  logic hreadyout, hresp, instr_end, return_from_irq;
  logic cpu_irq_req, inject_call, in_service, irq;
  logic [11:0] inject_addr;
  wire logic hready = hreadyout;
  int n_fail = 0, cmp_count = 0;
  initial forever #5 hclk = ~hclk;
  svi_cpu_model svi_cpu_model_inst (.*);
  svi_irq_unit svi_irq_unit_inst (.*);
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // Waits are bounded so a silent design cannot hang the run
  task automatic wt(input int s);
    logic [4:0] v;
    for (int i = 0; i < 40; i++) begin
      @(posedge hclk);
      v = {!in_service, instr_end & return_from_irq, instr_end,
           inject_call, hready};
      if (v[s]) return;
    end
    n_fail++;
    report_and_stop();
  endtask : wt
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    haddr <= {18'h0, a, 2'b00};
    hwrite <= w;
    htrans <= 2'h2;
    wt(0);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wt(0);
    if (!w) chk($sformatf("reg %h", a), {24'h0, d}, hrdata);
  endtask : bus
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    bus(0, 12'hf08, 8'h00);
    bus(1, 12'hf08, 8'ha5);
    bus(0, 12'hf08, 8'ha5);
    bus(0, 12'hf20, 8'h00);
    bus(1, 12'hf08, 8'h00);
    periph_event <= 4'hf;
    wakeup_timer_event <= 1;
    @(posedge hclk);
    periph_event <= 4'h0;
    wakeup_timer_event <= 0;
    bus(0, 12'hf09, 8'hf8);
    chk("req", 0, cpu_irq_req);
    bus(1, 12'hf09, 8'h7f);
    bus(0, 12'hf09, 8'h78);
    $display("registers done");
    bus(1, 12'hf08, 8'h18);
    wt(1);
    chk("call", 1, in_service);
    bus(1, 12'hf09, 8'hef);
    chk("req", 1, cpu_irq_req);
    ret_req <= 1;
    wt(3);
    ret_req <= 0;
    @(posedge hclk);
    chk("svc", 1, in_service);
    wt(2);
    repeat (2) @(posedge hclk);
    chk("svc", 0, in_service);
    wt(1);
    bus(1, 12'hf09, 8'h00);
    ret_req <= 1;
    wt(3);
    ret_req <= 0;
    wt(4);
    bus(0, 12'hf18, 8'h03);
    bus(1, 12'hf14, 8'h02);
    repeat (2) @(posedge hclk);
    chk("irq", 1, irq);
    bus(1, 12'hf18, 8'h02);
    repeat (2) @(posedge hclk);
    chk("irq", 0, irq);
    $display("service done");
    bus(1, 12'hf0c, 8'h80);
    port_a_line1 <= 0;
    port_a_line6 <= 0;
    port_a_line7 <= 0;
    repeat (8) @(posedge hclk);
    bus(0, 12'hf09, 8'h05);
    port_a_line1 <= 1;
    repeat (8) @(posedge hclk);
    bus(0, 12'hf09, 8'h07);
    $display("pins done");
    report_and_stop();
  end
endmodule : svi_irq_unit_tb
bind svi_irq_unit svi_irq_unit_assertions svi_irq_unit_assertions_inst (.*);
